// ===== logic/zsbt_transcoder.v
// Bipolar line transcoder: AMI, B8ZS, B6ZS and HDB3 encoder and decoder.
// Operation
// - Each one is a pulse of alternating polarity; each zero is the zero level.
// - Two successive pulses of equal polarity count as a bipolar violation.
// - B8ZS mode replaces every run of eight zeros with eight symbols.
// - B8ZS emits 000+-0-+ after positive, 000-+0+- after negative.
// - B8ZS violations sit at the fourth and seventh symbols of the run.
// - B6ZS mode replaces every run of six zeros with six symbols.
// - B6ZS emits 0+-0-+ after positive, 0-+0+- after negative.
// - B6ZS violations sit at the second and fifth symbols of the run.
// - HDB3 replaces every four zeros with a pattern ending in a violation.
// - HDB3 counts ones since last violation; odd gives 000V, even B00V.
// - In 000V the violation repeats the last pulse polarity.
// - In B00V the B opposes the last pulse and V matches B.
// - Encoder output is a positive rail and a negative rail; both low is zero.
// - Decoder turns patterns into zero runs, pulses into ones, zeros into zeros.
// - Decoder flags equal polarity pulse pairs outside a valid pattern.
// - Decoder raises rail error when both input rails are high together on a valid symbol.
`timescale 1ns/1ps
`include "zsbt_regs.vh"

module zsbt_transcoder (
	// Clock and reset
	input wire clk_sys,
	input wire reset,
	// Line code selection, held stable outside reset
	input wire [1:0] mode,
	// Encoder data input
	input wire nrz_in,
	input wire nrz_in_valid,
	// Encoder line output
	output reg positive_rail_out,
	output reg negative_rail_out,
	output reg tx_symbol_valid,
	// Decoder line input
	input wire pos_rail_in,
	input wire neg_rail_in,
	input wire rail_in_valid,
	output wire rail_in_ready,
	// Decoder data output
	output wire nrz_out,
	output wire nrz_out_valid,
	input wire nrz_out_ready,
	// Decoder status
	output reg unexpected_violation_flag,
	output reg rail_error,
	output reg pattern_detected
);

	// Zero run length for the selected code.
	reg [3:0] run_len;
	always @* begin
		case (mode)
		`ZSBT_MODE_B8: run_len = `ZSBT_RUN_B8;
		`ZSBT_MODE_B6: run_len = `ZSBT_RUN_B6;
		`ZSBT_MODE_HDB: run_len = `ZSBT_RUN_HDB;
		default: run_len = `ZSBT_RUN_NONE;
		endcase
	end

	// Encoder pipeline: data bit, substitution position and valid per entry.
	reg [`ZSBT_LAST:0] enc_bit_r;
	reg [`ZSBT_LAST:0] enc_vld_r;
	reg [4*`ZSBT_DEPTH-1:0] enc_tag_r;
	wire [`ZSBT_LAST:0] enc_bit_nxt;
	wire [`ZSBT_LAST:0] enc_vld_nxt;
	wire [4*`ZSBT_DEPTH-1:0] enc_tag_nxt;
	reg [3:0] zero_cnt_r;
	wire [3:0] zero_cnt_inc;
	wire enc_mark;

	assign zero_cnt_inc = zero_cnt_r + 4'h1;
	// A run is complete when the new zero brings the count to the run length.
	assign enc_mark = (run_len != `ZSBT_RUN_NONE) & ~nrz_in &
		(zero_cnt_inc == run_len);

	genvar gi;
	generate
		for (gi = 0; gi < `ZSBT_DEPTH; gi = gi + 1) begin : g_enc
			wire [3:0] pos_in_run;
			assign pos_in_run = run_len - gi[3:0];
			if (gi == 0) begin : g_head
				assign enc_bit_nxt[gi] = nrz_in;
				assign enc_vld_nxt[gi] = 1'b1;
				assign enc_tag_nxt[3:0] = enc_mark ? pos_in_run : 4'h0;
			end else begin : g_tail
				assign enc_bit_nxt[gi] = enc_bit_r[gi-1];
				assign enc_vld_nxt[gi] = enc_vld_r[gi-1];
				// Entries inside the completed run take their pattern position.
				assign enc_tag_nxt[4*gi+3:4*gi] =
					(enc_mark && (gi[3:0] < run_len)) ? pos_in_run :
					enc_tag_r[4*gi-1:4*gi-4];
			end
		end
	endgenerate

	// Encoder output stage on the oldest entry.
	reg pol_r;
	reg par_r;
	reg pat_pol_r;
	reg pat_even_r;
	reg [1:0] tx_sym;
	reg pol_nxt;
	reg par_nxt;
	reg ref_pol;
	reg ref_even;
	reg [1:0] sym_same;
	reg [1:0] sym_opp;
	wire [3:0] out_tag;
	wire out_bit;

	assign out_tag = enc_tag_r[4*`ZSBT_DEPTH-1:4*`ZSBT_DEPTH-4];
	assign out_bit = enc_bit_r[`ZSBT_LAST];

	always @* begin
		// Pattern reference is the polarity and parity seen at its first symbol.
		ref_pol = (out_tag == 4'h1) ? pol_r : pat_pol_r;
		ref_even = (out_tag == 4'h1) ? ~par_r : pat_even_r;
		sym_same = ref_pol ? `ZSBT_SYM_POS : `ZSBT_SYM_NEG;
		sym_opp = ref_pol ? `ZSBT_SYM_NEG : `ZSBT_SYM_POS;
		tx_sym = `ZSBT_SYM_ZERO;
		par_nxt = par_r;
		if (out_tag == 4'h0) begin
			if (out_bit) begin
				tx_sym = pol_r ? `ZSBT_SYM_NEG : `ZSBT_SYM_POS;
				par_nxt = ~par_r;
			end
		end else begin
			case (mode)
			`ZSBT_MODE_B8: begin
				case (out_tag)
				4'h4: tx_sym = sym_same;
				4'h5: tx_sym = sym_opp;
				4'h7: tx_sym = sym_opp;
				4'h8: tx_sym = sym_same;
				default: tx_sym = `ZSBT_SYM_ZERO;
				endcase
			end
			`ZSBT_MODE_B6: begin
				case (out_tag)
				4'h2: tx_sym = sym_same;
				4'h3: tx_sym = sym_opp;
				4'h5: tx_sym = sym_opp;
				4'h6: tx_sym = sym_same;
				default: tx_sym = `ZSBT_SYM_ZERO;
				endcase
			end
			`ZSBT_MODE_HDB: begin
				case (out_tag)
				4'h1: tx_sym = ref_even ? sym_opp : `ZSBT_SYM_ZERO;
				4'h4: begin
					tx_sym = ref_even ? sym_opp : sym_same;
					par_nxt = 1'b0;
				end
				default: tx_sym = `ZSBT_SYM_ZERO;
				endcase
			end
			default: tx_sym = `ZSBT_SYM_ZERO;
			endcase
		end
		// Every emitted pulse updates the last polarity, violations included.
		pol_nxt = (tx_sym == `ZSBT_SYM_ZERO) ? pol_r :
			(tx_sym == `ZSBT_SYM_POS);
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			enc_bit_r <= {`ZSBT_DEPTH{1'b0}};
			enc_vld_r <= {`ZSBT_DEPTH{1'b0}};
			enc_tag_r <= {4*`ZSBT_DEPTH{1'b0}};
			zero_cnt_r <= 4'h0;
			pol_r <= 1'b0;
			par_r <= 1'b0;
			pat_pol_r <= 1'b0;
			pat_even_r <= 1'b0;
			positive_rail_out <= 1'b0;
			negative_rail_out <= 1'b0;
			tx_symbol_valid <= 1'b0;
		end else begin
			tx_symbol_valid <= nrz_in_valid & enc_vld_r[`ZSBT_LAST];
			if (nrz_in_valid) begin
				enc_bit_r <= enc_bit_nxt;
				enc_vld_r <= enc_vld_nxt;
				enc_tag_r <= enc_tag_nxt;
				zero_cnt_r <= (nrz_in | enc_mark) ? 4'h0 : zero_cnt_inc;
				if (enc_vld_r[`ZSBT_LAST]) begin
					positive_rail_out <= tx_sym[1];
					negative_rail_out <= tx_sym[0];
					pol_r <= pol_nxt;
					par_r <= par_nxt;
					if (out_tag == 4'h1) begin
						pat_pol_r <= pol_r;
						pat_even_r <= ~par_r;
					end
				end
			end
		end
	end

	// Decoder pipeline: received symbol, zero override, violation, valid.
	reg [2*`ZSBT_DEPTH-1:0] dec_sym_r;
	reg [`ZSBT_LAST:0] dec_zero_r;
	reg [`ZSBT_LAST:0] dec_viol_r;
	reg [`ZSBT_LAST:0] dec_vld_r;
	wire [2*`ZSBT_DEPTH-1:0] dec_sym_nxt;
	wire [`ZSBT_LAST:0] dec_zero_nxt;
	wire [`ZSBT_LAST:0] dec_viol_nxt;
	wire [`ZSBT_LAST:0] dec_vld_nxt;
	reg rx_pol_r;
	reg rx_seen_r;
	wire [1:0] rx_sym;
	wire rx_pulse;
	wire rx_viol;
	wire dec_adv;
	wire buf_ready;
	wire [15:0] pat_minus;
	wire [15:0] pat_mask;
	wire match_fixed;
	wire match_hdb;
	wire dec_match;

	assign dec_adv = rail_in_valid & buf_ready;
	// A both-rails symbol is an error and enters the pipeline as a zero.
	assign rx_sym = (pos_rail_in & neg_rail_in) ? `ZSBT_SYM_ZERO :
		{pos_rail_in, neg_rail_in};
	assign rx_pulse = (rx_sym != `ZSBT_SYM_ZERO);
	assign rx_viol = rx_pulse & rx_seen_r &
		(rx_sym[1] == rx_pol_r);
	assign dec_sym_nxt = {dec_sym_r[2*`ZSBT_DEPTH-3:0], rx_sym};

	assign pat_minus = ((`ZSBT_PAT_PLUS & 16'haaaa) >> 1) |
		((`ZSBT_PAT_PLUS & 16'h5555) << 1);
	assign pat_mask = (mode == `ZSBT_MODE_B8) ? `ZSBT_MASK_B8 : `ZSBT_MASK_B6;
	assign match_fixed = ((mode == `ZSBT_MODE_B8) ||
		(mode == `ZSBT_MODE_B6)) &&
		(((dec_sym_nxt & pat_mask) == `ZSBT_PAT_PLUS) ||
		((dec_sym_nxt & pat_mask) == pat_minus));
	assign match_hdb = (mode == `ZSBT_MODE_HDB) && rx_viol &&
		(dec_sym_nxt[3:2] == `ZSBT_SYM_ZERO) &&
		(dec_sym_nxt[5:4] == `ZSBT_SYM_ZERO) &&
		((dec_sym_nxt[7:6] == `ZSBT_SYM_ZERO) ||
		(dec_sym_nxt[7:6] == rx_sym));
	assign dec_match = match_fixed | match_hdb;

	generate
		for (gi = 0; gi < `ZSBT_DEPTH; gi = gi + 1) begin : g_dec
			if (gi == 0) begin : g_head
				assign dec_zero_nxt[gi] = dec_match;
				assign dec_viol_nxt[gi] = rx_viol;
				assign dec_vld_nxt[gi] = 1'b1;
			end else begin : g_tail
				// Symbols inside a recognised pattern decode as zeros.
				assign dec_zero_nxt[gi] = (dec_match &&
					(gi[3:0] < run_len)) | dec_zero_r[gi-1];
				assign dec_viol_nxt[gi] = dec_viol_r[gi-1];
				assign dec_vld_nxt[gi] = dec_vld_r[gi-1];
			end
		end
	endgenerate

	wire dec_push;
	wire dec_bit;

	assign dec_push = dec_adv & dec_vld_r[`ZSBT_LAST];
	assign dec_bit = (dec_sym_r[2*`ZSBT_DEPTH-1:2*`ZSBT_DEPTH-2] !=
		`ZSBT_SYM_ZERO) & ~dec_zero_r[`ZSBT_LAST];

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dec_sym_r <= {2*`ZSBT_DEPTH{1'b0}};
			dec_zero_r <= {`ZSBT_DEPTH{1'b0}};
			dec_viol_r <= {`ZSBT_DEPTH{1'b0}};
			dec_vld_r <= {`ZSBT_DEPTH{1'b0}};
			rx_pol_r <= 1'b0;
			rx_seen_r <= 1'b0;
			unexpected_violation_flag <= 1'b0;
			rail_error <= 1'b0;
			pattern_detected <= 1'b0;
		end else begin
			rail_error <= rail_in_valid & pos_rail_in & neg_rail_in;
			pattern_detected <= dec_adv & dec_match;
			// Violations are judged once every pattern has had time to match.
			unexpected_violation_flag <= dec_push &
				dec_viol_r[`ZSBT_LAST] & ~dec_zero_r[`ZSBT_LAST];
			if (dec_adv) begin
				dec_sym_r <= dec_sym_nxt;
				dec_zero_r <= dec_zero_nxt;
				dec_viol_r <= dec_viol_nxt;
				dec_vld_r <= dec_vld_nxt;
				if (rx_pulse) begin
					rx_pol_r <= rx_sym[1];
					rx_seen_r <= 1'b1;
				end
			end
		end
	end

	// The buffer absorbs receiver stalls; when full it stalls the line input.
	zsbt_buf #(
		.WIDTH(1)
	) u_buf (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_valid(dec_push),
		.in_ready(buf_ready),
		.in_data(dec_bit),
		.out_valid(nrz_out_valid),
		.out_ready(nrz_out_ready),
		.out_data(nrz_out)
	);

	assign rail_in_ready = buf_ready;

endmodule // zsbt_transcoder

// ===== logic/zsbt_regs.vh
// Constants shared by the zero substitution bipolar transcoder files.
`ifndef ZSBT_REGS_VH
`define ZSBT_REGS_VH

// Line code selection.
`define ZSBT_MODE_AMI 2'h0
`define ZSBT_MODE_B8 2'h1
`define ZSBT_MODE_B6 2'h2
`define ZSBT_MODE_HDB 2'h3

// Zero run lengths that trigger a substitution.
`define ZSBT_RUN_NONE 4'h0
`define ZSBT_RUN_B8 4'h8
`define ZSBT_RUN_B6 4'h6
`define ZSBT_RUN_HDB 4'h4

// Pipeline depth in bits; equals the fixed latency in accepted bits.
`define ZSBT_DEPTH 8
`define ZSBT_LAST 7

// Symbol codes, {positive rail, negative rail}.
`define ZSBT_SYM_ZERO 2'h0
`define ZSBT_SYM_NEG 2'h1
`define ZSBT_SYM_POS 2'h2

// Received substitution pattern after a positive pulse, newest symbol in
// bits 1:0; B6 uses the low six symbols of the same pattern.
`define ZSBT_PAT_PLUS 16'h0246
`define ZSBT_MASK_B8 16'hffff
`define ZSBT_MASK_B6 16'h0fff

// Buffer slot count on the decoded data path.
`define ZSBT_BUF_SLOTS 2'h2

`endif

// ===== logic/zsbt_buf.v
// Two-entry valid/ready buffer on the decoded data path.
`timescale 1ns/1ps
`include "zsbt_regs.vh"

module zsbt_buf #(
	parameter WIDTH = 2
) (
	// Clock and reset
	input wire clk_sys,
	input wire reset,
	// Fill side
	input wire in_valid,
	output reg in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output reg out_valid,
	input wire out_ready,
	output reg [WIDTH-1:0] out_data
);

	reg [1:0] cnt_r;
	reg [1:0] cnt_nxt;
	reg [WIDTH-1:0] slot1_r;
	wire push;
	wire pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @* begin
		cnt_nxt = cnt_r;
		if (push & ~pop)
			cnt_nxt = cnt_r + 2'h1;
		else if (pop & ~push)
			cnt_nxt = cnt_r - 2'h1;
	end

	// Slot 0 is always the head so the output data come from a register.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cnt_r <= 2'h0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			out_data <= {WIDTH{1'b0}};
			slot1_r <= {WIDTH{1'b0}};
		end else begin
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt != `ZSBT_BUF_SLOTS);
			out_valid <= (cnt_nxt != 2'h0);
			if (pop) begin
				if (cnt_r == `ZSBT_BUF_SLOTS)
					out_data <= slot1_r;
				else
					out_data <= in_data;
				if (push)
					slot1_r <= in_data;
			end else if (push) begin
				if (cnt_r == 2'h0)
					out_data <= in_data;
				else
					slot1_r <= in_data;
			end
		end
	end

endmodule // zsbt_buf

// ===== bench/zsbt_chk.sv
// Port checker for the bipolar transcoder.
`timescale 1ns/1ps
`include "zsbt_regs.vh"
module zsbt_chk (
	// Clock and reset
	input wire clk_sys,
	input wire reset,
	// Inputs
	input wire [1:0] mode,
	input wire nrz_in_valid,
	input wire pos_rail_in,
	input wire neg_rail_in,
	input wire rail_in_valid,
	input wire nrz_out_ready,
	// Outputs
	input wire positive_rail_out,
	input wire negative_rail_out,
	input wire tx_symbol_valid,
	input wire rail_in_ready,
	input wire nrz_out,
	input wire nrz_out_valid,
	input wire rail_error,
	input wire pattern_detected
);
	reg last_pos_r;
	wire pulse = positive_rail_out || negative_rail_out;
	// Polarity of the last line pulse; reset leaves it negative.
	always @(posedge clk_sys or posedge reset) begin
		if (reset)
			last_pos_r <= 1'b0;
		else if (tx_symbol_valid && pulse)
			last_pos_r <= positive_rail_out;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_held; nrz_out_valid && !nrz_out_ready; endsequence
	sequence s_kept; nrz_out_valid && $stable(nrz_out); endsequence
	property p_excl; !(positive_rail_out && negative_rail_out); endproperty
	a_excl: assert property (p_excl) else $error("both rails out");
	property p_hold; !tx_symbol_valid |-> $stable(pulse); endproperty
	a_hold: assert property (p_hold) else $error("rails moved");
	property p_tx; tx_symbol_valid |-> $past(nrz_in_valid); endproperty
	a_tx: assert property (p_tx) else $error("symbol without bit");
	property p_alt;
		mode == `ZSBT_MODE_AMI && tx_symbol_valid && pulse
			|-> positive_rail_out != last_pos_r;
	endproperty
	a_alt: assert property (p_alt) else $error("polarity repeated");
	property p_err;
		rail_in_valid && pos_rail_in && neg_rail_in |=> rail_error;
	endproperty
	a_err: assert property (p_err) else $error("rail error missing");
	property p_ami; mode == `ZSBT_MODE_AMI |-> !pattern_detected; endproperty
	a_ami: assert property (p_ami) else $error("pattern in plain mode");
	property p_stall; s_held |=> s_kept; endproperty
	a_stall: assert property (p_stall) else $error("bit lost");
	property p_full; !rail_in_ready |-> nrz_out_valid; endproperty
	a_full: assert property (p_full) else $error("refused while empty");
endmodule // zsbt_chk
bind zsbt_transcoder zsbt_chk u_chk (.clk_sys(clk_sys), .reset(reset),
	.mode(mode), .nrz_in_valid(nrz_in_valid), .pos_rail_in(pos_rail_in),
	.neg_rail_in(neg_rail_in), .rail_in_valid(rail_in_valid),
	.nrz_out_ready(nrz_out_ready), .positive_rail_out(positive_rail_out),
	.negative_rail_out(negative_rail_out), .tx_symbol_valid(tx_symbol_valid),
	.rail_in_ready(rail_in_ready), .nrz_out(nrz_out),
	.nrz_out_valid(nrz_out_valid), .rail_error(rail_error),
	.pattern_detected(pattern_detected));

// ===== bench/zsbt_line_model.sv
// Line model: carries encoder symbols back to the decoder input.
`timescale 1ns/1ps
module zsbt_line_model (
	// Clock and reset
	input wire clk_sys,
	input wire reset,
	// Encoder side
	input wire positive_rail_out,
	input wire negative_rail_out,
	input wire tx_symbol_valid,
	// Decoder side
	output reg pos_rail_in = 1'b0,
	output reg neg_rail_in = 1'b0,
	output reg rail_in_valid = 1'b0,
	input wire rail_in_ready,
	// Pacing
	input wire slow
);
	logic [1:0] q[$];
	reg held;
	reg pace;
	task push(input logic [1:0] s);
		q.push_back(s);
	endtask
	// An offered symbol holds until taken; idle rails toggle to hide stale data.
	always @(posedge clk_sys) begin
		held = rail_in_valid && !rail_in_ready && !reset;
		pace = slow;
		if (reset)
			q.delete();
		else if (rail_in_valid && rail_in_ready)
			void'(q.pop_front());
		if (tx_symbol_valid && !reset)
			q.push_back({positive_rail_out, negative_rail_out});
		#1;
		if (!held && q.size() > 0 && !pace) begin
			rail_in_valid = 1'b1;
			{pos_rail_in, neg_rail_in} = q[0];
		end else if (!held) begin
			rail_in_valid = 1'b0;
			{pos_rail_in, neg_rail_in} = ~{pos_rail_in, neg_rail_in};
		end
	end
endmodule // zsbt_line_model

// ===== bench/zsbt_transcoder_tb.sv
// Self-checking testbench for the bipolar transcoder.
`timescale 1ns/1ps
`include "zsbt_regs.vh"
module zsbt_transcoder_tb;
	reg clk_sys = 1'b0;
	reg reset = 1'b1;
	reg [1:0] mode = 2'h0;
	reg nrz_in = 1'b0;
	reg nrz_in_valid = 1'b0;
	reg nrz_out_ready = 1'b1;
	reg slow = 1'b0;
	wire positive_rail_out, negative_rail_out, tx_symbol_valid;
	wire pos_rail_in, neg_rail_in, rail_in_valid, rail_in_ready;
	wire nrz_out, nrz_out_valid, unexpected_violation_flag;
	wire rail_error, pattern_detected;
	int fail_count = 0;
	int compares = 0;
	int n_pat, n_viol, n_err;
	logic [1:0] tx_q[$];
	logic rx_q[$];
	zsbt_transcoder dut (
		.clk_sys(clk_sys), .reset(reset), .mode(mode), .nrz_in(nrz_in),
		.nrz_in_valid(nrz_in_valid), .positive_rail_out(positive_rail_out),
		.negative_rail_out(negative_rail_out),
		.tx_symbol_valid(tx_symbol_valid), .pos_rail_in(pos_rail_in),
		.neg_rail_in(neg_rail_in), .rail_in_valid(rail_in_valid),
		.rail_in_ready(rail_in_ready), .nrz_out(nrz_out),
		.nrz_out_valid(nrz_out_valid), .nrz_out_ready(nrz_out_ready),
		.unexpected_violation_flag(unexpected_violation_flag),
		.rail_error(rail_error), .pattern_detected(pattern_detected));
	zsbt_line_model line (.clk_sys(clk_sys), .reset(reset),
		.positive_rail_out(positive_rail_out),
		.negative_rail_out(negative_rail_out),
		.tx_symbol_valid(tx_symbol_valid), .pos_rail_in(pos_rail_in),
		.neg_rail_in(neg_rail_in), .rail_in_valid(rail_in_valid),
		.rail_in_ready(rail_in_ready), .slow(slow));
	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (!reset) begin
			if (tx_symbol_valid)
				tx_q.push_back({positive_rail_out, negative_rail_out});
			if (nrz_out_valid && nrz_out_ready)
				rx_q.push_back(nrz_out);
			n_pat += pattern_detected;
			n_viol += unexpected_violation_flag;
			n_err += rail_error;
		end
	end
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task end_sim;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task restart(input logic [1:0] m);
		#1;
		reset = 1'b1;
		mode = m;
		repeat (6) @(posedge clk_sys);
		#1;
		{n_pat, n_viol, n_err} = 0;
		tx_q.delete();
		rx_q.delete();
		reset = 1'b0;
	endtask
	task wait_rx(input int n);
		for (int t = 0; t < 300 && rx_q.size() < n; t++)
			@(posedge clk_sys);
		if (rx_q.size() < n) begin
			check("decoded count", 8'h0, 8'h1);
			end_sim();
		end
	endtask
	function logic [1:0] sym(input byte c);
		return c == "+" ? `ZSBT_SYM_POS : c == "-" ? `ZSBT_SYM_NEG : 2'h0;
	endfunction
	// Bits plus sixteen flush ones, since encoder and decoder each hold eight.
	// The line is paced and the receiver stalled to fill the buffer.
	task run_code(input logic [1:0] m, input string b, input string s, int p);
		restart(m);
		for (int i = 0; i < b.len() + 16; i++) begin
			@(posedge clk_sys);
			#1;
			nrz_in_valid = 1'b1;
			nrz_in = i < b.len() ? b[i] == "1" : 1'b1;
			slow = i % 4 == 3;
			nrz_out_ready = i < b.len() + 2;
		end
		@(posedge clk_sys);
		#1;
		nrz_in_valid = 1'b0;
		slow = 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		nrz_out_ready = 1'b1;
		wait_rx(b.len());
		check("symbol count", tx_q.size(), b.len() + 8);
		for (int i = 0; i < s.len(); i++)
			check("symbol", tx_q[i], sym(s[i]));
		for (int i = 0; i < b.len(); i++)
			check("decoded bit", rx_q[i], b[i] == "1");
		check("patterns", n_pat, p);
		check("violations", n_viol, 0);
	endtask
	task t_ami;
		run_code(`ZSBT_MODE_AMI, "1100000000101", "+-00000000+0-", 0);
	endtask
	task t_b8;
		run_code(`ZSBT_MODE_B8, "100000000100000000",
			"+000+-0-+-000-+0+-", 2);
	endtask
	task t_b6;
		run_code(`ZSBT_MODE_B6, "10000001000000", "+0+-0-+-0-+0+-", 2);
	endtask
	task t_hdb;
		run_code(`ZSBT_MODE_HDB, "100001100001000010000110000",
			"+000+-+-00-+000+-000-+-+00+", 5);
	endtask
	// Same polarity pair and both rails high arrive from the line.
	task t_faults;
		restart(`ZSBT_MODE_AMI);
		line.push(`ZSBT_SYM_POS);
		line.push(`ZSBT_SYM_POS);
		line.push(2'h3);
		repeat (8) line.push(`ZSBT_SYM_ZERO);
		wait_rx(3);
		check("violation flag", n_viol, 1);
		check("rail error", n_err, 1);
		check("both rails bit", rx_q[2], 0);
	endtask
	initial begin
		t_ami();
		t_b8();
		t_b6();
		t_hdb();
		t_faults();
		end_sim();
	end
endmodule // zsbt_transcoder_tb
